// *** design/gpiob_pkg.sv ***
// constants for the eight-bit general purpose port
package gpiob_pkg;
  localparam int GPIOB_ADDR_W = 8;
  localparam int GPIOB_DATA_W = 8;
  localparam logic [7:0] GPIOB_OFS_DATA = 8'h01;
  localparam logic [7:0] GPIOB_OFS_DIR = 8'h05;
  localparam logic [7:0] GPIOB_OFS_PUE = 8'h0c;
  localparam logic [7:0] GPIOB_DIR_RST = 8'h00;
  localparam logic [7:0] GPIOB_PUE_RST = 8'h00;
  localparam logic [7:0] GPIOB_RD_NONE = 8'h00;
endpackage

// *** design/gpiob_port.sv ***
// eight-bit general purpose port with data, direction and pull-up registers
`timescale 1ns/1ps
module gpiob_port
  import gpiob_pkg::*;
(
  input wire logic ref_clk, // 100 MHz clock
  input wire logic rst, // synchronous reset, active high
  input wire logic [GPIOB_ADDR_W-1:0] addr, // register address
  input wire logic [GPIOB_DATA_W-1:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [GPIOB_DATA_W-1:0] rdata, // read data, cycle after rd
  input wire logic [7:0] pin_in, // pin levels from the pads
  output logic [7:0] pin_out, // pin output values
  output logic [7:0] pin_oe, // pin output enables
  output logic [7:0] pin_pullup // pull-up enables to the pads
);

  // registers seen by software
  logic [GPIOB_DATA_W-1:0] pin_data_latch;
  logic [GPIOB_DATA_W-1:0] pin_direction_control;
  logic [GPIOB_DATA_W-1:0] pin_pullup_enable;

  // registered pad control and read data
  logic [GPIOB_DATA_W-1:0] pull_on;
  logic [GPIOB_DATA_W-1:0] read_word;

  // two-stage synchroniser for the asynchronous pad levels
  logic [GPIOB_DATA_W-1:0] pin_meta;
  logic [GPIOB_DATA_W-1:0] pin_sync;

  // next values of the software registers
  logic [GPIOB_DATA_W-1:0] next_pin_data_latch;
  logic [GPIOB_DATA_W-1:0] next_pin_direction_control;
  logic [GPIOB_DATA_W-1:0] next_pin_pullup_enable;

  // next values of the pad side and the read path
  logic [GPIOB_DATA_W-1:0] next_pull_on;
  logic [GPIOB_DATA_W-1:0] next_read_word;
  logic [GPIOB_DATA_W-1:0] next_pin_meta;
  logic [GPIOB_DATA_W-1:0] next_pin_sync;

  // decoded selects and strobes
  logic hit_data;
  logic hit_dir;
  logic hit_pue;
  logic wr_data;
  logic wr_dir;
  logic wr_pue;
  logic rd_data;
  logic rd_dir;
  logic rd_pue;

  // register select decode, shared by the write and read paths
  function automatic logic gpiob_hit(
    input logic [GPIOB_ADDR_W-1:0] a,
    input logic [GPIOB_ADDR_W-1:0] ofs
  );
    if (a == ofs) begin
      return 1'b1;
    end
    return 1'b0;
  endfunction

  // a written register takes the bus data, otherwise keeps its value
  function automatic logic [GPIOB_DATA_W-1:0] gpiob_update(
    input logic [GPIOB_DATA_W-1:0] cur,
    input logic we,
    input logic [GPIOB_DATA_W-1:0] wd
  );
    if (we) begin
      return wd;
    end
    return cur;
  endfunction

  // driven pins report the latch, undriven pins the pad level
  function automatic logic [GPIOB_DATA_W-1:0] gpiob_mix(
    input logic [GPIOB_DATA_W-1:0] dir,
    input logic [GPIOB_DATA_W-1:0] drv,
    input logic [GPIOB_DATA_W-1:0] pad
  );
    logic [GPIOB_DATA_W-1:0] res;
    for (int i = 0; i < GPIOB_DATA_W; i++) begin
      if (dir[i]) begin
        res[i] = drv[i];
      end else begin
        res[i] = pad[i];
      end
    end
    return res;
  endfunction

  // pull-up only where enabled and the pin is not driven
  function automatic logic [GPIOB_DATA_W-1:0] gpiob_pull(
    input logic [GPIOB_DATA_W-1:0] pue,
    input logic [GPIOB_DATA_W-1:0] dir
  );
    logic [GPIOB_DATA_W-1:0] res;
    for (int i = 0; i < GPIOB_DATA_W; i++) begin
      if (dir[i]) begin
        res[i] = 1'b0;
      end else begin
        res[i] = pue[i];
      end
    end
    return res;
  endfunction

  always_comb begin
    hit_data = gpiob_hit(addr, GPIOB_OFS_DATA);
    hit_dir = gpiob_hit(addr, GPIOB_OFS_DIR);
    hit_pue = gpiob_hit(addr, GPIOB_OFS_PUE);
  end

  // data writes are taken during reset too; the other strobes are not
  always_comb begin
    wr_data = wr && hit_data;
    wr_dir = wr && hit_dir && !rst;
    wr_pue = wr && hit_pue && !rst;
    rd_data = rd && hit_data && !rst;
    rd_dir = rd && hit_dir && !rst;
    rd_pue = rd && hit_pue && !rst;
  end

  // no reset term: the latch keeps its contents through reset
  always_comb begin
    next_pin_data_latch = gpiob_update(pin_data_latch, wr_data,
      wdata);
  end

  always_ff @(posedge ref_clk) begin
    pin_data_latch <= next_pin_data_latch;
  end

  // first stage: may go metastable, read only by the second stage
  always_comb begin
    next_pin_meta = pin_in;
  end

  always_ff @(posedge ref_clk) begin
    pin_meta <= next_pin_meta;
  end

  // second stage: the only pad level the read path may use
  always_comb begin
    next_pin_sync = pin_meta;
  end

  always_ff @(posedge ref_clk) begin
    pin_sync <= next_pin_sync;
  end

  // direction: 1 drives the pin, 0 leaves it an input
  always_comb begin
    if (rst) begin
      next_pin_direction_control = GPIOB_DIR_RST;
    end else begin
      next_pin_direction_control = gpiob_update(pin_direction_control,
        wr_dir, wdata);
    end
  end

  always_ff @(posedge ref_clk) begin
    pin_direction_control <= next_pin_direction_control;
  end

  // pull-up enables, one per pin
  always_comb begin
    if (rst) begin
      next_pin_pullup_enable = GPIOB_PUE_RST;
    end else begin
      next_pin_pullup_enable = gpiob_update(pin_pullup_enable, wr_pue,
        wdata);
    end
  end

  always_ff @(posedge ref_clk) begin
    pin_pullup_enable <= next_pin_pullup_enable;
  end

  // registered from the values that stand next cycle, so it never lags
  always_comb begin
    if (rst) begin
      next_pull_on = GPIOB_PUE_RST;
    end else begin
      next_pull_on = gpiob_pull(next_pin_pullup_enable,
        next_pin_direction_control);
    end
  end

  always_ff @(posedge ref_clk) begin
    pull_on <= next_pull_on;
  end

  // read data stand one cycle after the strobe and are zero otherwise;
  // unmapped addresses read as zero as well
  always_comb begin
    next_read_word = GPIOB_RD_NONE;
    if (rd_data) begin
      next_read_word = gpiob_mix(pin_direction_control, pin_data_latch,
        pin_sync);
    end else if (rd_dir) begin
      next_read_word = pin_direction_control;
    end else if (rd_pue) begin
      next_read_word = pin_pullup_enable;
    end
  end

  always_ff @(posedge ref_clk) begin
    read_word <= next_read_word;
  end

  // pad side; the latch is unknown until first written, which is harmless
  // while every pin is still an input
  assign pin_out = pin_data_latch;
  assign pin_oe = pin_direction_control;
  assign pin_pullup = pull_on;
  assign rdata = read_word;
endmodule

// *** sim/gpiob_props.sv ***
// assertions on the port outputs
`timescale 1ns/1ps
module gpiob_props import gpiob_pkg::*; (input wire logic ref_clk, rst, wr,
  input wire logic rd, input wire logic [7:0] addr, wdata, rdata,
  input wire logic [7:0] pin_out, pin_oe, pin_pullup, pin_in);
  logic seen = 1'b0;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  always_ff @(posedge ref_clk) seen <= seen | (wr && addr == GPIOB_OFS_DATA);
  a_latch_write: assert property (wr && addr == GPIOB_OFS_DATA |=>
    pin_out == $past(wdata)) else $error("latch write");
  a_latch_kept: assert property (disable iff (1'b0)
    seen && rst && !wr |=> $stable(pin_out)) else $error("latch kept");
  a_reset_clear: assert property (disable iff (1'b0) rst |=>
    pin_oe == 8'h00 && pin_pullup == 8'h00 && rdata == 8'h00)
    else $error("reset");
  a_dir_write: assert property (wr && addr == GPIOB_OFS_DIR |=>
    pin_oe == $past(wdata)) else $error("direction");
  a_pue_write: assert property (wr && addr == GPIOB_OFS_PUE |=>
    (pin_pullup | pin_oe) == ($past(wdata) | pin_oe)) else $error("pue");
  a_pullup_gate: assert property ((pin_pullup & pin_oe) == 8'h00)
    else $error("pull-up on output");
  a_read_latch: assert property (rd && addr == GPIOB_OFS_DATA |=>
    (rdata & pin_oe) == (pin_out & pin_oe)) else $error("read mix");
  a_read_pins: assert property (rd && addr == GPIOB_OFS_DATA |=>
    (rdata & ~pin_oe) == ($past(pin_in, 3) & ~pin_oe))
    else $error("read pins");
  a_read_idle: assert property (!rd |=> rdata == 8'h00)
    else $error("read idle");
endmodule
bind gpiob_port gpiob_props PROPS(.ref_clk, .rst, .wr, .rd, .addr, .wdata,
  .rdata, .pin_out, .pin_oe, .pin_pullup, .pin_in);

// *** sim/gpiob_pads.sv ***
// pads: driven pins echo the latch, idle inputs follow the pull-up
`timescale 1ns/1ps
module gpiob_pads (input wire logic [7:0] pin_out, pin_oe, pin_pullup,
  output logic [7:0] pin_in);
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & pin_pullup);
endmodule

// *** sim/testbench.sv ***
// self-checking bench for the port
`timescale 1ns/1ps
`define CHK(a,e) begin checks_done++; if ((a) !== (e)) begin miscompares++; \
  $display("mismatch %0t %h %h", $time, a, e); end end
module testbench;
  import gpiob_pkg::*;
  logic ref_clk = 0, rst = 1, wr = 0, rd = 0;
  logic [7:0] addr = 0, wdata = 0, rdata, pin_in, pin_out, pin_oe, pin_pullup;
  int miscompares = 0, checks_done = 0, cyc = 0;
  always #5 ref_clk = ~ref_clk;
  gpiob_port DUT(.ref_clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .pin_in,
    .pin_out, .pin_oe, .pin_pullup);
  gpiob_pads PADS(.pin_out, .pin_oe, .pin_pullup, .pin_in);
  task wrr(input logic [7:0] a, d);
    @(posedge ref_clk) begin addr <= a; wdata <= d; wr <= 1; end
    @(posedge ref_clk) wr <= 0;
  endtask
  task rdc(input logic [7:0] a, e);
    @(posedge ref_clk) begin addr <= a; rd <= 1; end
    @(posedge ref_clk) rd <= 0;
    #1 `CHK(rdata, e)
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge ref_clk) if (++cyc > 500) begin miscompares++; end_of_test; end
  initial begin
    repeat (3) @(posedge ref_clk);
    rst <= 0;
    rdc(GPIOB_OFS_DIR, 8'h00);
    wrr(GPIOB_OFS_DATA, 8'h3c);
    wrr(GPIOB_OFS_DIR, 8'h0f);
    wrr(GPIOB_OFS_PUE, 8'hff);
    #1 `CHK(pin_pullup, 8'hf0)
    repeat (3) @(posedge ref_clk);
    rdc(GPIOB_OFS_DATA, 8'hfc);
    rdc(GPIOB_OFS_PUE, 8'hff);
    @(posedge ref_clk) rst <= 1;
    @(posedge ref_clk) rst <= 0;
    #1 `CHK(pin_out, 8'h3c)
    `CHK(pin_oe, 8'h00)
    `CHK(pin_pullup, 8'h00)
    wrr(GPIOB_OFS_DIR, 8'hff);
    #1 `CHK(pin_oe, 8'hff)
    rdc(GPIOB_OFS_DATA, 8'h3c);
    rdc(8'h02, 8'h00);
    end_of_test;
  end
endmodule
